// ### lcd_driver.sv
// Purpose: drives a character display over a 4/8-bit bus
// Assumes: display pins synchronous to clk, one clock
// Notes:   host stream -> formatter -> fifo -> bus engine
`timescale 1ns/1ps
`include "lcd_defines.svh"
module lcd_driver
   import lcd_pkg::*;
#(
   parameter int unsigned CMD_CYC    = `LCD_CMD_CYC,
   parameter int unsigned CHR_CYC    = `LCD_CHR_CYC,
   parameter int unsigned PWR_CYC    = `LCD_PWR_CYC,
   parameter int          FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // host item stream
   input  wire logic        item_valid,
   output logic             item_ready,
   input  wire lcd_fmt_type item_mode,
   input  wire logic [15:0] item_value,
   input  wire logic [7:0]  item_count,
   // memory read request and answer
   input  wire logic        rd_start,
   output logic             rd_ready,
   input  wire logic        rd_addr_given,
   input  wire logic [7:0]  rd_addr,
   input  wire logic [7:0]  rd_len,
   output logic             rd_data_valid,
   output logic      [7:0]  rd_data,
   // configuration
   input  wire logic        bus_width_setting,
   input  wire logic        data_nibble_high,
   input  wire logic [2:0]  line_count,
   input  wire logic [2:0]  e_bit,
   input  wire logic [2:0]  rs_bit,
   input  wire logic [2:0]  rw_line_bit,
   // init flag
   input  wire logic        init_clear,
   output logic             init_done,
   // display pins
   output logic      [7:0]  data_out,
   output logic             data_oe_b,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  rw_line_port
);
   localparam int unsigned E_CYC = `LCD_E_CYC;
   // whole state of the engine
   typedef struct packed {
      lcd_state_type st;
      logic [31:0]   cnt;
      logic [2:0]    step;
      logic [7:0]    xfer;
      logic          rs;
      logic          rw;
      logic          e;
      logic          nib;
      logic          single;
      logic          esc;
      logic          init_mode;
      logic          init_done;
      logic          rd_req;
      logic          rd_addr_pend;
      logic [7:0]    rd_addr;
      logic [7:0]    rd_left;
      logic [7:0]    rd_buf;
      logic [7:0]    rd_data;
      logic          rd_valid;
      logic [7:0]    dport;
      logic [7:0]    ctl;
      logic          dir_b;
   } lcd_top_state_type;
   lcd_top_state_type s, next_s;
   logic       rst_meta;   // reset sync first stage
   logic       rst_sync;   // reset used by all logic
   logic       f_valid;    // fifo byte present
   logic       f_ready;    // engine takes fifo byte
   logic [7:0] f_data;     // fifo head byte
   logic       fm_valid;   // formatter byte present
   logic       fm_ready;   // fifo accepts byte
   logic [7:0] fm_data;    // formatter byte
   // start one bus transfer
   function automatic lcd_top_state_type lcd_launch(input lcd_top_state_type t,
      input logic [7:0] b, input logic rsv, input logic rwv, input logic sgl);
      t.st     = S_SETUP;
      t.cnt    = '0;
      t.xfer   = b;
      t.rs     = rsv;
      t.rw     = rwv;
      t.single = sgl;
      t.nib    = 1'b0;
      return t;
   endfunction : lcd_launch
   // init sequence bytes
   function automatic logic [7:0] lcd_init_byte(input logic [2:0] k,
      input logic w8, input logic [2:0] lines);
      logic [7:0] fs;
      fs = `LCD_FSET;
      fs[`LCD_FS_DL] = w8;
      fs[`LCD_FS_N]  = (lines > 3'h1);
      case (k)
         3'h3:    return w8 ? `LCD_WAKE : `LCD_FSET;
         3'h4:    return fs;
         3'h5:    return `LCD_DISP_ON;
         3'h6:    return `LCD_CLEAR;
         3'h7:    return `LCD_ENTRY;
         default: return `LCD_WAKE;
      endcase
   endfunction : lcd_init_byte
   // one control bit at its chosen position
   function automatic logic [7:0] lcd_pin(input logic v, input logic [2:0] b);
      return v ? (8'h01 << b) : 8'h00;
   endfunction : lcd_pin
   // reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end
   // item formatting
   lcd_fmt u_fmt (
      .clk        (clk),
      .rst_b      (rst_sync),
      .item_valid (item_valid),
      .item_ready (item_ready),
      .item_mode  (item_mode),
      .item_value (item_value),
      .item_count (item_count),
      .out_valid  (fm_valid),
      .out_ready  (fm_ready),
      .out_data   (fm_data)
   );
   // byte buffer, stalls formatter when full
   lcd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_b     (rst_sync),
      .in_valid  (fm_valid),
      .in_ready  (fm_ready),
      .in_data   (fm_data),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );
   assign rd_ready      = !s.rd_req;
   assign rd_data_valid = s.rd_valid;
   assign rd_data       = s.rd_data;
   assign init_done     = s.init_done;
   assign data_out      = s.dport;
   assign data_oe_b     = s.dir_b;
   assign rw_line_port  = s.ctl;
   // engine sequencing
   always_comb begin
      logic [7:0]  nb;
      logic [31:0] gap;
      nb  = data_nibble_high ? {4'h0, data_in[7:4]} : {4'h0, data_in[3:0]};
      gap = (s.init_mode || (!s.rs && !s.rw)) ? CMD_CYC : CHR_CYC;
      next_s          = s;
      next_s.rd_valid = 1'b0;
      f_ready         = 1'b0;
      // read request capture
      if (rd_start && !s.rd_req && rd_len != 8'h00) begin
         next_s.rd_req       = 1'b1;
         next_s.rd_addr_pend = rd_addr_given;
         next_s.rd_addr      = rd_addr;
         next_s.rd_left      = rd_len;
      end
      // host may drop the flag for a re-init
      if (init_clear) begin
         next_s.init_done = 1'b0;
      end
      case (s.st)
         S_IDLE: begin
            if (!s.init_done && (f_valid || s.rd_req)) begin // first use, or flag cleared
               next_s.init_mode = 1'b1;
               next_s.step      = 3'h0;
               next_s.cnt       = '0;
               next_s.st        = S_POWER;
            end else if (s.init_done && s.rd_req && s.rd_addr_pend) begin
               // address command, glyph_ram or display ram
               next_s = lcd_launch(next_s, s.rd_addr[7] ? s.rd_addr
                                   : (s.rd_addr | `LCD_CGRAM), 1'b0, 1'b0, 1'b0);
               next_s.rd_addr_pend = 1'b0;
            end else if (s.init_done && s.rd_req) begin // data read cycle
               next_s = lcd_launch(next_s, 8'h00, 1'b1, 1'b1, 1'b0);
            end else if (s.init_done && f_valid) begin
               f_ready = 1'b1;
               if (!s.esc && f_data == `LCD_ESC) begin
                  next_s.esc = 1'b1;
               end else begin // commands go out as received
                  next_s     = lcd_launch(next_s, f_data, !s.esc, 1'b0, 1'b0);
                  next_s.esc = 1'b0;
               end
            end
         end
         S_POWER: begin
            // start-up wait of the display
            next_s.cnt = s.cnt + 32'h1;
            if (s.cnt >= PWR_CYC - 1) begin
               next_s = lcd_launch(next_s, `LCD_WAKE, 1'b0, 1'b0, 1'b1);
            end
         end
         S_SETUP: begin
            // select and data settle before enable
            next_s.cnt = s.cnt + 32'h1;
            if (s.cnt >= E_CYC - 1) begin
               next_s.cnt = '0;
               next_s.e   = 1'b1;
               next_s.st  = S_EHIGH;
            end
         end
         S_EHIGH: begin
            next_s.cnt = s.cnt + 32'h1;
            if (s.cnt >= E_CYC - 1) begin
               next_s.cnt = '0;
               next_s.e   = 1'b0;
               next_s.st  = S_ELOW;
               if (s.rw && bus_width_setting) begin
                  next_s.rd_buf = data_in;
               end else if (s.rw && !s.nib) begin
                  next_s.rd_buf = {nb[3:0], 4'h0};
               end else if (s.rw) begin
                  next_s.rd_buf = {s.rd_buf[7:4], nb[3:0]};
               end
            end
         end
         S_ELOW: begin
            next_s.cnt = s.cnt + 32'h1;
            if (s.cnt >= E_CYC - 1) begin
               next_s.cnt = '0;
               if (!bus_width_setting && !s.single && !s.nib) begin
                  next_s.nib = 1'b1;
                  next_s.st  = S_SETUP;
               end else begin
                  next_s.st = S_GAP;
               end
            end
         end
         S_GAP: begin
            // controller busy time
            next_s.cnt = s.cnt + 32'h1;
            if (s.cnt >= gap - 1) begin
               next_s.st = S_IDLE;
               if (s.init_mode && s.step == `LCD_INIT_LAST) begin
                  next_s.init_mode = 1'b0;
                  next_s.init_done = 1'b1;
               end else if (s.init_mode) begin
                  next_s.step = s.step + 3'h1;
                  next_s = lcd_launch(next_s, lcd_init_byte(s.step + 3'h1, bus_width_setting,
                                      line_count), 1'b0, 1'b0, (s.step + 3'h1) < `LCD_WAKE_STEPS);
               end else if (s.rw) begin
                  next_s.rd_valid = 1'b1;
                  next_s.rd_data  = s.rd_buf;
                  next_s.rd_left  = s.rd_left - 8'h01;
                  next_s.rd_req   = (s.rd_left > 8'h01);
               end
            end
         end
         default: begin
            next_s.st = S_IDLE;
         end
      endcase
      // pin images from the next state
      next_s.ctl = lcd_pin(next_s.e, e_bit) | lcd_pin(next_s.rs, rs_bit)
                 | lcd_pin(next_s.rw, rw_line_bit);
      if (bus_width_setting) begin
         next_s.dport = next_s.xfer;
      end else begin
         nb = next_s.nib ? {4'h0, next_s.xfer[3:0]} : {4'h0, next_s.xfer[7:4]};
         next_s.dport = data_nibble_high ? {nb[3:0], 4'h0} : nb;
      end
      next_s.dir_b = next_s.rw;
   end
   // state register
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         s <= '{st: S_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end
   default clocking cb @(posedge clk); endclocking // checks on the engine
   default disable iff (!rst_sync);
   sequence sq_hi_nib;
      s.st == S_ELOW && !s.nib && !bus_width_setting && !s.single && s.cnt == E_CYC - 1;
   endsequence
   sequence sq_lo_nib;
      s.st == S_SETUP && s.nib && data_out == (data_nibble_high ? {s.xfer[3:0], 4'h0}
                                               : {4'h0, s.xfer[3:0]});
   endsequence
   a_esc_prefix: assert property (
      s.st == S_IDLE && s.init_done && !s.rd_req && f_valid && !s.esc && f_data == `LCD_ESC
      |=> s.esc && s.st == S_IDLE)
      else $error("escape byte not taken as prefix");
   a_cmd_select: assert property (
      s.st == S_IDLE && s.init_done && !s.rd_req && f_valid && s.esc
      |=> s.st == S_SETUP && !s.rs && !s.rw && s.xfer == $past(f_data))
      else $error("command byte altered or sent as data");
   a_pin_map: assert property (s.st == S_EHIGH |-> rw_line_port[e_bit] && rw_line_port[rs_bit] == s.rs)
      else $error("enable or select pin wrong");
   a_read_dir: assert property (s.st == S_EHIGH && s.rw |-> data_oe_b && rw_line_port[rw_line_bit])
      else $error("read without releasing bus");
   a_init_first: assert property (s.st == S_IDLE && !s.init_done |=> s.st != S_SETUP)
      else $error("transfer before init");
   a_nib_order: assert property (sq_hi_nib |=> sq_lo_nib)
      else $error("lower nibble not second");
   a_byte_wide: assert property (s.st == S_EHIGH && bus_width_setting |-> data_out == s.xfer)
      else $error("8-bit bus not whole byte");
   a_power_wait: assert property (s.st == S_IDLE ##1 s.st == S_POWER |-> (s.st == S_POWER)[*8])
      else $error("start-up wait too short");
   a_gap_hold: assert property (s.st == S_ELOW ##1 s.st == S_GAP |-> (s.st == S_GAP && !s.e)[*8])
      else $error("write delay too short");
endmodule : lcd_driver

// ### lcd_defines.svh
// Purpose: shared constants of the character display driver
// Assumes: 100 MHz clock
// Notes:   times kept in their own unit, cycles derived
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH

// clock rate
`define LCD_CLK_MHZ    100
// escape byte that marks a command
`define LCD_ESC        8'hfe
// post-write delays, enable width and start-up wait
`define LCD_CMD_US     1500
`define LCD_CHR_US     44
`define LCD_PWR_MS     500
`define LCD_E_NS       450
`define LCD_CMD_CYC    (`LCD_CMD_US * `LCD_CLK_MHZ)
`define LCD_CHR_CYC    (`LCD_CHR_US * `LCD_CLK_MHZ)
`define LCD_PWR_CYC    (`LCD_PWR_MS * 1000 * `LCD_CLK_MHZ)
`define LCD_E_CYC      ((`LCD_E_NS * `LCD_CLK_MHZ + 999) / 1000)
// controller commands used by the init sequence
`define LCD_WAKE       8'h30
`define LCD_FSET       8'h20
`define LCD_FS_DL      4
`define LCD_FS_N       3
`define LCD_DISP_ON    8'h0c
`define LCD_CLEAR      8'h01
`define LCD_ENTRY      8'h06
`define LCD_INIT_LAST  3'h7
`define LCD_WAKE_STEPS 3'h4
// memory address command bases
`define LCD_CGRAM      8'h40
`define LCD_DDRAM      8'h80
// ascii digit bases
`define LCD_ASC_0      8'h30
`define LCD_ASC_A      8'h37

`endif

// ### lcd_pkg.sv
// Purpose: types of the character display driver
// Assumes: nothing
// Notes:   state codes are one-hot
package lcd_pkg;
   // bus engine states
   typedef enum logic [5:0] {
      S_IDLE  = 6'h01,
      S_POWER = 6'h02,
      S_SETUP = 6'h04,
      S_EHIGH = 6'h08,
      S_ELOW  = 6'h10,
      S_GAP   = 6'h20
   } lcd_state_type;
   // item formatting modes
   typedef enum logic [2:0] {
      FMT_RAW = 3'h0,
      FMT_DEC = 3'h1,
      FMT_BIN = 3'h2,
      FMT_HEX = 3'h3,
      FMT_REP = 3'h4
   } lcd_fmt_type;
endpackage : lcd_pkg

// ### lcd_fifo.sv
// Purpose: byte buffer between formatter and bus engine
// Assumes: synchronous reset copy, one clock
// Notes:   in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
module lcd_fifo
   import lcd_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   // whole state of the buffer
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } lcd_fifo_state_type;
   lcd_fifo_state_type s, next_s;

   // pointer step with wrap
   function automatic logic [AW-1:0] lcd_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : lcd_inc

   assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s.cnt != '0);
   assign out_data  = s.mem[s.rp];

   // push and pop
   always_comb begin
      logic push;
      logic pop;
      push   = in_valid && in_ready;
      pop    = out_valid && out_ready;
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp        = lcd_inc(s.wp);
      end
      if (pop) begin
         next_s.rp = lcd_inc(s.rp);
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + (AW+1)'(1);
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - (AW+1)'(1);
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   a_full_stall: assert property (@(posedge clk) disable iff (!rst_b)
      (s.cnt == (AW+1)'(DEPTH)) |-> !in_ready ##1 $stable(s.wp))
      else $error("fifo accepted while full");
endmodule : lcd_fifo

// ### lcd_fmt.sv
// Purpose: turns host items into ascii byte stream
// Assumes: 16-bit values, digits without leading zeros
// Notes:   raw mode passes array bytes one per item
`timescale 1ns/1ps
`include "lcd_defines.svh"
module lcd_fmt
   import lcd_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // host items
   input  wire logic        item_valid,
   output logic             item_ready,
   input  wire lcd_fmt_type item_mode,
   input  wire logic [15:0] item_value,
   input  wire logic [7:0]  item_count,
   // byte stream
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic      [7:0]  out_data
);
   // whole state of the formatter
   typedef struct packed {
      logic             busy;
      logic             emit;
      lcd_fmt_type      mode;
      logic [15:0]      val;
      logic [7:0]       cnt;
      logic [15:0][3:0] dig;
      logic [4:0]       n;
      logic [7:0]       ch;
   } lcd_fmt_state_type;
   lcd_fmt_state_type s, next_s;

   // radix of a digit mode
   function automatic logic [15:0] lcd_radix(input lcd_fmt_type m);
      case (m)
         FMT_BIN: return 16'h0002;
         FMT_HEX: return 16'h0010;
         default: return 16'h000a;
      endcase
   endfunction : lcd_radix

   // digit to ascii
   function automatic logic [7:0] lcd_asc(input logic [3:0] d);
      return (d < 4'ha) ? `LCD_ASC_0 + {4'h0, d} : `LCD_ASC_A + {4'h0, d};
   endfunction : lcd_asc

   assign item_ready = !s.busy;
   assign out_valid  = s.busy && s.emit;
   assign out_data   = s.ch;

   // accept, convert, emit
   always_comb begin
      logic [15:0] r;
      r      = lcd_radix(s.mode);
      next_s = s;
      if (!s.busy) begin
         // new item
         if (item_valid) begin
            next_s.busy = !(item_mode == FMT_REP && item_count == 8'h00);
            next_s.mode = item_mode;
            next_s.val  = item_value;
            next_s.cnt  = item_count;
            next_s.ch   = item_value[7:0];
            next_s.n    = 5'h00;
            next_s.emit = (item_mode == FMT_RAW) || (item_mode == FMT_REP);
         end
      end else if (!s.emit) begin
         // one digit per cycle, least significant first
         next_s.dig[s.n[3:0]] = 4'((s.val % r));
         next_s.val = s.val / r;
         next_s.n   = s.n + 5'h01;
         if (s.val / r == 16'h0000) begin
            next_s.emit = 1'b1;
            next_s.ch   = lcd_asc(4'((s.val % r)));
         end
      end else if (out_ready) begin
         // byte taken
         case (s.mode)
            FMT_RAW: begin
               next_s.busy = 1'b0;
            end
            FMT_REP: begin
               next_s.cnt  = s.cnt - 8'h01;
               next_s.busy = (s.cnt > 8'h01);
            end
            default: begin
               next_s.n    = s.n - 5'h01;
               next_s.busy = (s.n > 5'h01);
               next_s.ch   = lcd_asc(s.dig[4'(s.n - 5'h02)]);
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   a_digit_ascii: assert property (@(posedge clk) disable iff (!rst_b)
      out_valid && s.mode != FMT_RAW && s.mode != FMT_REP |->
      (out_data >= `LCD_ASC_0 && out_data <= 8'h46))
      else $error("formatted digit not ascii");
endmodule : lcd_fmt

// ### lcd_disp_model.sv
// Purpose: display module model that logs each write strobe
// Assumes: enable, select and rw sit at the configured control bits
// Notes:   data_in shows a read byte only while a read strobe is high
`timescale 1ns/1ps
module lcd_disp_model (
   // clock
   input  wire logic       clk,
   // display pins
   input  wire logic [7:0] ctl,
   input  wire logic [7:0] dout,
   output logic      [7:0] din,
   // wiring setup
   input  wire logic [2:0] e_bit,
   input  wire logic [2:0] rs_bit,
   input  wire logic [2:0] rw_bit,
   input  wire logic       w8,
   input  wire logic       hi,
   // strobe log
   output logic            ev,
   output logic      [8:0] ev_val
);
   logic       e_q  = 1'b0;   // enable one cycle ago
   logic       half = 1'b0;   // 4-bit read: lower nibble next
   logic [7:0] rd_n = 8'h5a;  // next byte handed on a read
   logic [7:0] lane;          // latched lane, nibble moved to top
   logic [3:0] rd_nib;        // nibble handed on a 4-bit read
   // pick the lane the way the wiring says
   assign lane = w8 ? dout : (hi ? {dout[7:4], 4'h0} : {dout[3:0], 4'h0});
   // upper nibble first, shown on both port halves
   assign rd_nib = half ? rd_n[3:0] : rd_n[7:4];
   // only a read strobe drives the lines, else a changed value
   assign din = (ctl[rw_bit] && ctl[e_bit]) ? (w8 ? rd_n : {2{rd_nib}}) : ~rd_n;
   // latch at enable fall, log writes, step read data
   always @(posedge clk) begin
      e_q    <= ctl[e_bit];
      ev     <= e_q && !ctl[e_bit] && !ctl[rw_bit];
      ev_val <= {ctl[rs_bit], lane};
      if (e_q && !ctl[e_bit] && ctl[rw_bit]) begin
         half <= !w8 && !half;
         if (w8 || half) rd_n <= rd_n + 8'h01;
      end
   end
endmodule : lcd_disp_model

// ### lcd_driver_test.sv
// Purpose: self-checking bench of the display driver
// Assumes: short delay parameters, model logs strobes
// Notes:   expectations queued by the driver side, popped on strobes
`timescale 1ns/1ps
module lcd_driver_test;
   import lcd_pkg::*;
   logic        clk, rst_b, item_valid, item_ready, rd_start, rd_ready, rd_addr_given, esc;
   logic        rd_data_valid, bus_width_setting, data_nibble_high, init_clear, init_done, data_oe_b, ev;
   lcd_fmt_type item_mode;
   logic [15:0] item_value, seed;
   logic [7:0]  item_count, rd_addr, rd_len, rd_data, data_out, data_in, rw_line_port, rd_nx;
   logic [2:0]  line_count, e_bit, rs_bit, rw_line_bit;
   logic [8:0]  ev_val;
   logic [8:0]  exp_q[$];  // expected strobes {select, lane}
   logic [7:0]  rd_q[$];   // expected read bytes
   int          failures, tests_run;
   lcd_driver #(.CMD_CYC(200), .CHR_CYC(50), .PWR_CYC(16)) u_dut (.clk, .rst_b, .item_valid, .item_ready,
      .item_mode, .item_value, .item_count, .rd_start, .rd_ready, .rd_addr_given, .rd_addr, .rd_len,
      .rd_data_valid, .rd_data, .bus_width_setting, .data_nibble_high, .line_count, .e_bit, .rs_bit,
      .rw_line_bit, .init_clear, .init_done, .data_out, .data_oe_b, .data_in, .rw_line_port);
   lcd_disp_model u_disp (.clk, .ctl(rw_line_port), .dout(data_out), .din(data_in), .e_bit, .rs_bit,
      .rw_bit(rw_line_bit), .w8(bus_width_setting), .hi(data_nibble_high), .ev, .ev_val);
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic test_done();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic check(string what, logic [8:0] seen, logic [8:0] expv);
      tests_run++;
      if (seen !== expv) begin
         failures++;
         $display("Error %s expected %h seen %h", what, expv, seen);
      end
   endtask : check
   // one byte as the bus carries it
   task automatic put(logic rs, logic [7:0] b);
      if (bus_width_setting) exp_q.push_back({rs, b});
      else begin
         exp_q.push_back({rs, b[7:4], 4'h0});
         exp_q.push_back({rs, b[3:0], 4'h0});
      end
   endtask : put
   task automatic put_init();
      repeat (3) exp_q.push_back(9'h030);
      exp_q.push_back(bus_width_setting ? 9'h030 : 9'h020);
      put(1'b0, {3'h1, bus_width_setting, line_count > 3'h1, 3'h0});
      put(1'b0, 8'h0c);
      put(1'b0, 8'h01);
      put(1'b0, 8'h06);
   endtask : put_init
   task automatic put_num(logic [15:0] v, int base);
      logic [7:0] d[$];
      do begin
         d.push_front(8'(v % base) + ((v % base) < 10 ? 8'h30 : 8'h37));
         v = v / 16'(base);
      end while (v != 16'h0);
      foreach (d[i]) put(1'b1, d[i]);
   endtask : put_num
   task automatic bounded(input bit stuck);
      if (stuck) begin
         failures++;
         test_done();
      end
   endtask : bounded
   task automatic send(lcd_fmt_type m, logic [15:0] v, logic [7:0] c = 8'h00);
      int n;
      case (m)
         FMT_RAW: if (esc) begin
            put(1'b0, v[7:0]);
            esc = 1'b0;
         end else if (v[7:0] == 8'hfe) esc = 1'b1;
         else put(1'b1, v[7:0]);
         FMT_DEC: put_num(v, 10);
         FMT_BIN: put_num(v, 2);
         FMT_HEX: put_num(v, 16);
         default: repeat (c) put(1'b1, v[7:0]);
      endcase
      @(posedge clk); #1;
      {item_valid, item_mode, item_value, item_count} = {1'b1, m, v, c};
      for (n = 0; !item_ready && n < 5000; n++) @(posedge clk) #1;
      bounded(n == 5000);
      @(posedge clk); #1;
      item_valid = 1'b0;
   endtask : send
   task automatic rd(logic g, logic [7:0] a, logic [7:0] len);
      int n;
      if (g) put(1'b0, a[7] ? a : a | 8'h40);
      repeat (len) rd_q.push_back(rd_nx++);
      @(posedge clk); #1;
      {rd_start, rd_addr_given, rd_addr, rd_len} = {1'b1, g, a, len};
      for (n = 0; !rd_ready && n < 5000; n++) @(posedge clk) #1;
      bounded(n == 5000);
      @(posedge clk); #1;
      rd_start = 1'b0;
   endtask : rd
   task automatic drain();
      int n;
      for (n = 0; (exp_q.size() || rd_q.size()) && n < 60000; n++) @(posedge clk);
      bounded(n == 60000);
      repeat (210) @(posedge clk);
   endtask : drain
   task automatic reinit(logic w8, logic hi, logic [2:0] ln, logic [2:0] e, logic [2:0] rs, logic [2:0] rw);
      @(posedge clk); #1;
      {init_clear, bus_width_setting, data_nibble_high, line_count, e_bit, rs_bit, rw_line_bit} = {1'b1, w8, hi, ln, e, rs, rw};
      @(posedge clk); #1;
      init_clear = 1'b0;
      @(posedge clk); #1;
      check("init_done", init_done, 9'h0);
      put_init();
   endtask : reinit
   // twelve command codes, escapes, text and numbers
   task automatic exercise();
      logic [7:0] cmds[12] = '{8'h01, 8'h02, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h14, 8'h80, 8'hc0, 8'h94, 8'hd4, 8'h84};
      foreach (cmds[i]) begin
         send(FMT_RAW, 16'h00fe);
         send(FMT_RAW, {8'h00, cmds[i]});
      end
      send(FMT_RAW, 16'h00fe);
      send(FMT_RAW, 16'h00fe);
      send(FMT_RAW, 16'h0041);
      repeat (2) begin
         seed = lfsr(seed);
         send(FMT_DEC, seed);
         send(FMT_HEX, seed);
         send(FMT_BIN, {12'h0, seed[3:0]});
      end
      send(FMT_DEC, 16'h0);
      send(FMT_REP, 16'h002a, 8'h03);
      send(FMT_REP, 16'h002b, 8'h00);
      drain();
      check("init_done", init_done, 9'h1);
   endtask : exercise
   // strobe and read watcher
   always @(posedge clk) begin
      if (ev) check("strobe", ev_val, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
      if (ev) check("data_oe_b", {8'h00, data_oe_b}, 9'h000);
      if (rd_data_valid) check("rd_data", {1'b0, rd_data}, {1'b0, rd_q.size() ? rd_q.pop_front() : 8'hxx});
   end
   initial begin
      {rst_b, item_valid, item_mode, item_value, item_count, esc, init_clear} = '0;
      {rd_start, rd_addr_given, rd_addr, rd_len, data_nibble_high} = '0;
      {bus_width_setting, line_count, e_bit, rs_bit, rw_line_bit} = {1'b1, 3'h2, 3'h1, 3'h0, 3'h2};
      {failures, tests_run, seed, rd_nx} = {32'h0, 32'h0, 16'h0031, 8'h5a};
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clk);
      put_init();
      exercise();
      rd(1'b1, 8'h85, 8'h02);
      rd(1'b1, 8'h03, 8'h01);
      rd(1'b0, 8'h00, 8'h01);
      drain();
      reinit(1'b0, 1'b1, 3'h4, 3'h7, 3'h5, 3'h3);
      exercise();
      rd(1'b1, 8'h10, 8'h02);
      drain();
      reinit(1'b0, 1'b0, 3'h1, 3'h6, 3'h4, 3'h0);
      exercise();
      test_done();
   end
endmodule : lcd_driver_test
